// file: src/mia_mmd_access.sv
// top of the indirect extended-register access block: the direct register
// bank behind the serial management port plus the pointer-based extended space.
// assumes the port address strap is static while reset is low and after it.
//
// Function
// - access control at 0x0D, address/data at 0x0E
// - standard regs indirect too, except those two
// - access control bits 4:0 select device
// - only device address all ones is honoured
// - bits 15:14 pick address/data/increment function
// - function 00 reaches the address pointer
// - function 01 reaches pointed register, pointer kept
// - function 10 increments after reads and writes
// - function 11 increments after writes only
// - address function reads return current pointer
// - 0x401F writes rewrite the same register
// - 0x401F reads keep returning same register
// - 0x801F/0xC01F writes walk upward through addresses
// - 0x801F reads walk upward through addresses
// - direct frames address 32 sixteen-bit registers
`default_nettype none
module mia_mmd_access (
  input  wire logic                clk,            // 125 MHz
  input  wire logic                reset_n,        // synchronous, active low
  input  wire logic                mdc,            // management clock pin
  input  wire logic                mdio_i,         // management data pin level
  output logic                     mdio_o,         // management data out
  output logic                     mdio_oe,        // management data enable
  input  wire mia_pkg::mia_regad_t phy_addr_strap, // port address strap
  output mia_pkg::mia_word_t       ext_pointer     // current extended pointer
);
  import mia_pkg::*;

  mia_word_t  mmd_access_control_q;                // access-control register
  mia_word_t  ext_ptr_q;                           // extended-address pointer
  mia_word_t  rd_data_q;                           // read answer to the frame engine
  mia_word_t  std_q [MIA_STD_DEPTH];               // plain direct registers
  mia_word_t  ext_q [MIA_EXT_DEPTH];               // extended register storage
  mia_regad_t phy_addr_q;                          // captured strap
  logic       strap_done_q;                        // strap captured
  logic       rd_req;                              // read header accepted
  logic       rd_done;                             // read frame complete
  logic       wr_req;                              // write frame complete
  mia_regad_t reg_addr;                            // frame register address
  mia_word_t  wr_data;                             // frame write data
  mia_func_t  func;                                // current function field
  logic       devad_ok;                            // device address honoured
  logic       ad_hit;                              // frame targets address/data, device honoured

  // pointer value lands in the direct registers other than the two access registers
  function automatic logic is_std(input mia_word_t p);
    is_std = (p < MIA_STD_REGS) && (p[4:0] != MIA_OFS_MMD_ACCESS_CONTROL)
             && (p[4:0] != MIA_OFS_MMD_ADDRESS_DATA);
  endfunction

  // pointer value lands in the extended storage window
  function automatic logic is_ext(input mia_word_t p);
    is_ext = (p >= MIA_EXT_BASE) && (16'(p - MIA_EXT_BASE) < 16'(MIA_EXT_DEPTH));
  endfunction

  // serial frame decode and answer
  mia_mdio_frame u_frame (
    .clk      (clk),
    .reset_n  (reset_n),
    .mdc      (mdc),
    .mdio_i   (mdio_i),
    .mdio_o   (mdio_o),
    .mdio_oe  (mdio_oe),
    .phy_addr (phy_addr_q),
    .rd_req   (rd_req),
    .rd_done  (rd_done),
    .wr_req   (wr_req),
    .reg_addr (reg_addr),
    .wr_data  (wr_data),
    .rd_data  (rd_data_q)
  );

  // strap capture in the first cycle after reset release
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strap_done_q <= 1'b0;
      phy_addr_q   <= 5'h00;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      phy_addr_q   <= phy_addr_strap;
    end
  end

  assign func        = mmd_access_control_q[MIA_FUNC_HI:MIA_FUNC_LO];
  assign devad_ok    = mmd_access_control_q[MIA_DEVAD_HI:MIA_DEVAD_LO] == MIA_DEVAD_VENDOR;
  assign ad_hit      = (reg_addr == MIA_OFS_MMD_ADDRESS_DATA) && devad_ok;
  assign ext_pointer = ext_ptr_q;

  // access-control register, written only by a direct frame
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mmd_access_control_q <= MIA_ACR_RST;
    end else if (wr_req && reg_addr == MIA_OFS_MMD_ACCESS_CONTROL) begin
      mmd_access_control_q <= wr_data;
    end
  end

  // extended pointer: load, post-increment with 16-bit wrap
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ext_ptr_q <= MIA_PTR_RST;
    end else if (wr_req && ad_hit) begin
      if (func == MIA_FN_ADDR) begin
        ext_ptr_q <= wr_data;
      end else if (func != MIA_FN_DATA) begin
        ext_ptr_q <= ext_ptr_q + 16'h0001;
      end
    end else if (rd_done && ad_hit && func == MIA_FN_INC_RW) begin
      ext_ptr_q <= ext_ptr_q + 16'h0001;
    end
  end

  // register storage: direct writes and data-function writes through the pointer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < MIA_STD_DEPTH; i++) begin
        std_q[i] <= MIA_MEM_RST;
      end
      for (int j = 0; j < MIA_EXT_DEPTH; j++) begin
        ext_q[j] <= MIA_MEM_RST;
      end
    end else if (wr_req) begin
      if (reg_addr != MIA_OFS_MMD_ACCESS_CONTROL && reg_addr != MIA_OFS_MMD_ADDRESS_DATA) begin
        std_q[reg_addr] <= wr_data;
      end else if (ad_hit && func != MIA_FN_ADDR) begin
        if (is_std(ext_ptr_q)) begin
          std_q[ext_ptr_q[4:0]] <= wr_data;
        end else if (is_ext(ext_ptr_q)) begin
          ext_q[6'(ext_ptr_q - MIA_EXT_BASE)] <= wr_data;
        end
      end
    end
  end

  // read answer captured when a read header is accepted
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data_q <= MIA_MEM_RST;
    end else if (rd_req) begin
      if (reg_addr == MIA_OFS_MMD_ACCESS_CONTROL) begin
        rd_data_q <= mmd_access_control_q;
      end else if (reg_addr != MIA_OFS_MMD_ADDRESS_DATA) begin
        rd_data_q <= std_q[reg_addr];
      end else if (!devad_ok) begin
        rd_data_q <= MIA_MEM_RST;
      end else if (func == MIA_FN_ADDR) begin
        rd_data_q <= ext_ptr_q;
      end else if (is_std(ext_ptr_q)) begin
        rd_data_q <= std_q[ext_ptr_q[4:0]];
      end else if (is_ext(ext_ptr_q)) begin
        rd_data_q <= ext_q[6'(ext_ptr_q - MIA_EXT_BASE)];
      end else begin
        rd_data_q <= MIA_MEM_RST;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_acr_write;
    wr_req && reg_addr == MIA_OFS_MMD_ACCESS_CONTROL |=> mmd_access_control_q == $past(wr_data);
  endproperty
  a_acr_write: assert property (p_acr_write) else $error("access control not loaded");

  property p_ind_self_ignored;
    wr_req && ad_hit && func != MIA_FN_ADDR && ext_ptr_q < MIA_STD_REGS
      && ext_ptr_q[4:0] == MIA_OFS_MMD_ACCESS_CONTROL |=> $stable(mmd_access_control_q);
  endproperty
  a_ind_self_ignored: assert property (p_ind_self_ignored) else $error("indirect hit access control");

  property p_devad_ignored;
    wr_req && reg_addr == MIA_OFS_MMD_ADDRESS_DATA && !devad_ok |=> $stable(ext_ptr_q);
  endproperty
  a_devad_ignored: assert property (p_devad_ignored) else $error("foreign device address acted");

  property p_addr_write;
    wr_req && ad_hit && func == MIA_FN_ADDR |=> ext_ptr_q == $past(wr_data);
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("pointer not loaded");

  property p_noinc;
    (wr_req || rd_done) && ad_hit && func == MIA_FN_DATA |=> $stable(ext_ptr_q) [*2];
  endproperty
  a_noinc: assert property (p_noinc) else $error("pointer moved without increment");

  property p_inc_rw_read;
    rd_done && ad_hit && func == MIA_FN_INC_RW |=> ext_ptr_q == 16'($past(ext_ptr_q) + 16'h0001);
  endproperty
  a_inc_rw_read: assert property (p_inc_rw_read) else $error("no increment after read");

  property p_inc_wr_read;
    rd_done && ad_hit && func == MIA_FN_INC_WR |=> $stable(ext_ptr_q);
  endproperty
  a_inc_wr_read: assert property (p_inc_wr_read) else $error("read moved write-only pointer");

  property p_rd_ptr;
    rd_req && ad_hit && func == MIA_FN_ADDR |=> rd_data_q == $past(ext_ptr_q);
  endproperty
  a_rd_ptr: assert property (p_rd_ptr) else $error("pointer read mismatch");

  property p_inc_write;
    wr_req && ad_hit && func[1] |=> ext_ptr_q == 16'($past(ext_ptr_q) + 16'h0001);
  endproperty
  a_inc_write: assert property (p_inc_write) else $error("no increment after write");

  c_addr_write: cover property (wr_req && ad_hit && func == MIA_FN_ADDR);
  c_ext_write:  cover property (wr_req && ad_hit && func == MIA_FN_DATA && is_ext(ext_ptr_q));
  c_inc_read:   cover property (rd_done && ad_hit && func == MIA_FN_INC_RW);
  c_wrap:       cover property (ext_ptr_q == 16'h0000 && $past(ext_ptr_q) == 16'hFFFF);
endmodule
`default_nettype wire

// file: src/mia_pkg.sv
// package for the indirect extended-register access block: offsets, fields,
// reset values, function codes and frame sizes shared by the design files.
// assumes a single 125 MHz clock domain; the management clock arrives as a pin.
`default_nettype none
package mia_pkg;
  typedef logic [15:0] mia_word_t;                            // one 16-bit management word
  typedef logic [4:0]  mia_regad_t;                           // five-bit register address
  typedef logic [1:0]  mia_func_t;                            // access function field

  // direct management register offsets
  localparam mia_regad_t MIA_OFS_MMD_ACCESS_CONTROL = 5'h0D;  // access-control register
  localparam mia_regad_t MIA_OFS_MMD_ADDRESS_DATA   = 5'h0E;  // address/data register

  // access-control field positions
  localparam int MIA_FUNC_HI  = 15;                           // function field top bit
  localparam int MIA_FUNC_LO  = 14;                           // function field low bit
  localparam int MIA_DEVAD_HI = 4;                            // device-address top bit
  localparam int MIA_DEVAD_LO = 0;                            // device-address low bit

  // device address that is honoured
  localparam mia_regad_t MIA_DEVAD_VENDOR = 5'h1F;            // all ones

  // function encodings
  localparam mia_func_t MIA_FN_ADDR   = 2'h0;                 // pointer access
  localparam mia_func_t MIA_FN_DATA   = 2'h1;                 // data, no increment
  localparam mia_func_t MIA_FN_INC_RW = 2'h2;                 // data, increment on reads and writes
  localparam mia_func_t MIA_FN_INC_WR = 2'h3;                 // data, increment on writes only

  // reset values
  localparam mia_word_t MIA_ACR_RST = 16'h0000;               // access control after reset
  localparam mia_word_t MIA_PTR_RST = 16'h0000;               // extended pointer after reset
  localparam mia_word_t MIA_MEM_RST = 16'h0000;               // register storage after reset

  // extended space layout
  localparam mia_word_t MIA_STD_REGS  = 16'h0020;             // pointer values below this hit direct regs
  localparam mia_word_t MIA_EXT_BASE  = 16'h0020;             // first extended storage address
  localparam int        MIA_EXT_DEPTH = 64;                   // extended storage words
  localparam int        MIA_STD_DEPTH = 32;                   // direct register count

  // serial frame sizes and opcodes
  localparam logic [5:0] MIA_PRE_ONES  = 6'h20;               // preamble ones needed
  localparam logic [4:0] MIA_HDR_LAST  = 5'h0C;               // last header bit index (13 bits)
  localparam logic [4:0] MIA_DATA_LAST = 5'h0F;               // last data bit index
  localparam logic [1:0] MIA_OP_RD     = 2'h2;                // read opcode
  localparam logic [1:0] MIA_OP_WR     = 2'h1;                // write opcode

  typedef enum logic [1:0] {MIA_FR_PRE, MIA_FR_HDR, MIA_FR_TA, MIA_FR_DATA} mia_frame_e;
endpackage
`default_nettype wire

// file: src/mia_mdio_frame.sv
// serial management frame engine: samples the management clock and data pins,
// decodes clause 22 frames and hands register reads and writes to the bank.
// assumes mdc is far slower than clk (at least four clk cycles per half period).
`default_nettype none
module mia_mdio_frame (
  input  wire logic                clk,       // 125 MHz
  input  wire logic                reset_n,   // synchronous, active low
  input  wire logic                mdc,       // management clock pin
  input  wire logic                mdio_i,    // management data pin level
  output logic                     mdio_o,    // data driven on the pin
  output logic                     mdio_oe,   // high while driving
  input  wire mia_pkg::mia_regad_t phy_addr,  // this port's address
  output logic                     rd_req,    // pulse: read header accepted
  output logic                     rd_done,   // pulse: read frame finished
  output logic                     wr_req,    // pulse: write frame finished
  output mia_pkg::mia_regad_t      reg_addr,  // register of current frame
  output mia_pkg::mia_word_t       wr_data,   // write data
  input  wire mia_pkg::mia_word_t  rd_data    // read data, valid a cycle after rd_req
);
  import mia_pkg::*;

  logic [2:0]  mdc_sync_q;                  // mdc synchroniser
  logic [2:0]  mdio_sync_q;                 // mdio synchroniser
  logic        mdc_lvl_q;                   // filtered mdc level
  logic        mdio_lvl_q;                  // filtered mdio level
  logic        rise;                        // mdc rising edge seen
  mia_frame_e  state_q;                     // frame position
  logic [4:0]  cnt_q;                       // bit counter
  logic [5:0]  ones_q;                      // preamble ones seen
  logic [12:0] hdr_q;                       // header shift
  logic [12:0] hdr_d;                       // header including current bit
  logic        is_rd_q;                     // frame is a read to us
  logic        is_wr_q;                     // frame is a write to us
  logic [15:0] in_q;                        // incoming data shift
  logic [15:0] out_q;                       // outgoing data shift

  // three-stage sampling; a change counts when stages two and three agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mdc_sync_q  <= 3'h0;
      mdio_sync_q <= 3'h7;
      mdc_lvl_q   <= 1'b0;
      mdio_lvl_q  <= 1'b1;
    end else begin
      mdc_sync_q  <= {mdc_sync_q[1:0], mdc};
      mdio_sync_q <= {mdio_sync_q[1:0], mdio_i};
      if (mdc_sync_q[1] == mdc_sync_q[2]) begin
        mdc_lvl_q <= mdc_sync_q[2];
      end
      if (mdio_sync_q[1] == mdio_sync_q[2]) begin
        mdio_lvl_q <= mdio_sync_q[2];
      end
    end
  end

  assign rise  = mdc_sync_q[1] & mdc_sync_q[2] & ~mdc_lvl_q;
  assign hdr_d = {hdr_q[11:0], mdio_lvl_q};

  // frame sequencer: preamble, start, opcode, port and register address, turnaround, data
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q  <= MIA_FR_PRE;
      cnt_q    <= 5'h00;
      ones_q   <= 6'h00;
      hdr_q    <= 13'h0000;
      is_rd_q  <= 1'b0;
      is_wr_q  <= 1'b0;
      in_q     <= 16'h0000;
      reg_addr <= 5'h00;
      wr_data  <= 16'h0000;
      rd_req   <= 1'b0;
      rd_done  <= 1'b0;
      wr_req   <= 1'b0;
    end else begin
      rd_req  <= 1'b0;
      rd_done <= 1'b0;
      wr_req  <= 1'b0;
      if (rise) begin
        unique case (state_q)
          MIA_FR_PRE: begin
            if (mdio_lvl_q) begin
              if (ones_q != MIA_PRE_ONES) begin
                ones_q <= ones_q + 6'h01;
              end
            end else begin
              ones_q <= 6'h00;
              if (ones_q == MIA_PRE_ONES) begin
                state_q <= MIA_FR_HDR;
                cnt_q   <= 5'h00;
              end
            end
          end
          MIA_FR_HDR: begin
            hdr_q <= hdr_d;
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == MIA_HDR_LAST) begin
              // the five-bit address field picks one of 32 word registers
              state_q  <= MIA_FR_TA;
              cnt_q    <= 5'h00;
              reg_addr <= hdr_d[4:0];
              is_rd_q  <= hdr_d[12] && hdr_d[9:5] == phy_addr && hdr_d[11:10] == MIA_OP_RD;
              is_wr_q  <= hdr_d[12] && hdr_d[9:5] == phy_addr && hdr_d[11:10] == MIA_OP_WR;
              rd_req   <= hdr_d[12] && hdr_d[9:5] == phy_addr && hdr_d[11:10] == MIA_OP_RD;
            end
          end
          MIA_FR_TA: begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q[0]) begin
              state_q <= MIA_FR_DATA;
              cnt_q   <= 5'h00;
            end
          end
          MIA_FR_DATA: begin
            cnt_q <= cnt_q + 5'h01;
            in_q  <= {in_q[14:0], mdio_lvl_q};
            if (cnt_q == MIA_DATA_LAST) begin
              state_q <= MIA_FR_PRE;
              wr_data <= {in_q[14:0], mdio_lvl_q};
              wr_req  <= is_wr_q;
              rd_done <= is_rd_q;
            end
          end
        endcase
      end
    end
  end

  // read answer: release first turnaround bit, drive zero, then sixteen data bits
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mdio_o  <= 1'b1;
      mdio_oe <= 1'b0;
      out_q   <= 16'h0000;
    end else if (rise && is_rd_q) begin
      if (state_q == MIA_FR_TA && !cnt_q[0]) begin
        mdio_oe <= 1'b1;
        mdio_o  <= 1'b0;
      end else if (state_q == MIA_FR_TA) begin
        mdio_o <= rd_data[15];
        out_q  <= {rd_data[14:0], 1'b0};
      end else if (state_q == MIA_FR_DATA && cnt_q == MIA_DATA_LAST) begin
        mdio_oe <= 1'b0;
        mdio_o  <= 1'b1;
      end else if (state_q == MIA_FR_DATA) begin
        mdio_o <= out_q[15];
        out_q  <= {out_q[14:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/mia_sta_model.sv
// station management model: sends whole clause 22 frames on mdc and data.
// assumes the bench resolves the shared wire (pull-up, device drive) into mdio_line.
`default_nettype none
module mia_sta_model (
  input  wire logic clk,       // bench clock, 125 MHz
  input  wire logic mdio_line, // resolved wire level
  output logic      mdc,       // management clock, still between frames
  output logic      sta_o,     // level the station drives
  output logic      sta_oe     // high while the station drives
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: clock low, wire released to the pull-up
  initial begin
    mdc = 1'b0;
    sta_o = 1'b1;
    sta_oe = 1'b0;
  end
  // preamble, start, opcode, addresses, turnaround, 16 data bits msb first;
  // each bit is 4 clk low then 4 clk high (64 ns), wire sampled just before the rise
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
                      input logic [15:0] wd, output logic [17:0] seen);
    logic [63:0] bits;
    bits = {32'hFFFFFFFF, 2'h1, op, phy, regad, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      @(posedge clk);
      mdc    <= 1'b0;
      sta_o  <= bits[i];
      sta_oe <= !(op == 2'h2 && i < 18); // read: released from the first turnaround bit
      repeat (3) @(posedge clk);
      @(negedge clk);
      seen = {seen[16:0], mdio_line};
      @(posedge clk);
      mdc <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    sta_oe <= 1'b0; // release after the whole word
  endtask
endmodule
`default_nettype wire

// file: sim/mia_mmd_access_tb.sv
// testbench of the indirect extended-register access block: corner table, then random traffic.
// assumes the station model drives all frames; expectations come from a reference bank here.
`default_nettype none
module mia_mmd_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mia_pkg::*;
  logic        clk, reset_n, mdc, sta_o, sta_oe, mdio_o, mdio_oe, mdio_line; // pins
  mia_regad_t  strap;                                                        // port address
  mia_word_t   ext_pointer, acr, ptr;                                        // design and reference
  mia_word_t   std_m [32];                                                   // reference direct regs
  mia_word_t   ext_m [64];                                                   // reference extended regs
  logic [17:0] seen;                                                         // turnaround and data
  logic [31:0] r;                                                            // random draw
  int          seed = 58, bad_count = 0, samples_checked = 0;
  // corner table: {wr, regad, data}
  localparam logic [27:0] CORNER [28] = '{28'h10D001F, 28'h10EFFFF, 28'h00E0000, 28'h10D801F,
    28'h00E0000, 28'h10D001F, 28'h10E0020, 28'h10D401F, 28'h10E1234, 28'h00E0000, 28'h00E0000,
    28'h10DC01F, 28'h10E5678, 28'h00E0000, 28'h10D801F, 28'h10E9ABC, 28'h00E0000, 28'h10D001F,
    28'h10E000D, 28'h10D401F, 28'h10EBEEF, 28'h00E0000, 28'h10E0003, 28'h10E4321, 28'h0030000,
    28'h10D401E, 28'h10E1111, 28'h00E0000};
  // shared wire with pull-up
  assign mdio_line = (mdio_oe === 1'b1) ? mdio_o : (sta_oe ? sta_o : 1'b1);
  mia_mmd_access mia_mmd_access_inst (.clk(clk), .reset_n(reset_n), .mdc(mdc), .mdio_i(mdio_line),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .phy_addr_strap(strap), .ext_pointer(ext_pointer));
  mia_sta_model mia_sta_model_inst (.clk(clk), .mdio_line(mdio_line), .mdc(mdc), .sta_o(sta_o),
    .sta_oe(sta_oe));
  // one compare for every word result
  task automatic check(input string what, input mia_word_t exp, input mia_word_t got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // indirect read through the pointer
  function automatic mia_word_t ind_rd(mia_word_t p);
    if (p < 16'h0020) return (p == 16'h000D || p == 16'h000E) ? 16'h0000 : std_m[p[4:0]];
    return (p < 16'h0060) ? ext_m[6'(p - 16'h0020)] : 16'h0000;
  endfunction
  // one frame plus the reference bank's view of it
  task automatic op(input logic wr, input mia_regad_t ra, input mia_word_t d);
    mia_word_t e;
    logic      hit;
    hit = (ra == 5'h0E) && (acr[4:0] == 5'h1F);
    e = (ra == 5'h0D) ? acr : (ra != 5'h0E) ? std_m[ra] : !hit ? 16'h0000 : (acr[15:14] == 2'h0) ? ptr : ind_rd(ptr);
    mia_sta_model_inst.xfer(wr ? 2'h1 : 2'h2, strap, ra, d, seen);
    if (!wr) check("read data", e, seen[15:0]);
    if (!wr) check("turnaround", 16'h0002, {14'h0, seen[17:16]});
    if (wr && ra == 5'h0D) acr = d;
    else if (wr && ra != 5'h0E) std_m[ra] = d;
    else if (hit && wr && acr[15:14] == 2'h0) ptr = d;
    else if (hit && acr[15:14] != 2'h0) begin
      if (wr && ptr >= 16'h0020 && ptr < 16'h0060) ext_m[6'(ptr - 16'h0020)] = d;
      else if (wr && ptr < 16'h0020 && ptr != 16'h000D && ptr != 16'h000E) std_m[ptr[4:0]] = d;
      if (acr[15:14] == 2'h2 || (wr && acr[15:14] == 2'h3)) ptr = ptr + 16'h0001; // wraps at 16 bits
    end
    repeat (4) @(posedge clk);
    check("pointer", ptr, ext_pointer);
    check("drive released", 16'h0000, {15'h0, mdio_oe});
  endtask
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  // main sequence
  initial begin
    reset_n = 1'b0;
    strap = 5'($random(seed));
    acr = 16'h0000;
    ptr = 16'h0000;
    foreach (std_m[i]) std_m[i] = 16'h0000;
    foreach (ext_m[i]) ext_m[i] = 16'h0000;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (16) @(posedge clk);
    check("reset pointer", 16'h0000, ext_pointer);
    op(1'b0, 5'h0E, 16'h0000);
    op(1'b1, 5'h0E, 16'h0055);
    // frames for another port address and an unknown opcode are ignored
    mia_sta_model_inst.xfer(2'h2, strap ^ 5'h01, 5'h0D, 16'h0000, seen);
    check("foreign read", 16'hFFFF, seen[15:0]);
    mia_sta_model_inst.xfer(2'h3, strap, 5'h0D, 16'h1234, seen);
    op(1'b0, 5'h0D, 16'h0000);
    foreach (CORNER[i]) op(CORNER[i][24], CORNER[i][20:16], CORNER[i][15:0]);
    repeat (60) begin
      r = $random(seed);
      case (r[2:0])
        3'h0, 3'h1: op(1'b1, 5'h0D, {r[9:8], 9'h000, (r[10] | r[11]) ? 5'h1F : r[16:12]});
        3'h2: op(1'b1, 5'h0E, {9'h000, r[14:8]});
        3'h3: op(1'b1, 5'h0E, r[31:16]);
        3'h4, 3'h5: op(1'b0, 5'h0E, 16'h0000);
        3'h6: op(1'b1, r[20:16], r[15:0]);
        default: op(1'b0, r[20:16], 16'h0000);
      endcase
    end
    complete_run();
  end
endmodule
`default_nettype wire
